// file: rpps_far_model.sv
// peripheral and pin side model of the pin select block
`timescale 1ns/1ns
module rpps_far_model
(
	input wire clk,
	input wire [19:0] per_set,
	input wire [25:0] pin_set,
	output reg [19:0] periph_out = 20'h00000,
	output reg [25:0] pin_in = 26'h0000000
);
	// registered peripheral outputs and pin levels
	always @(posedge clk)
	begin
		periph_out <= per_set;
		pin_in <= pin_set;
	end
endmodule // rpps_far_model

// file: rpps_monitor.sv
// assertion checker for the pin select block
`timescale 1ns/1ns
module rpps_monitor #(parameter NUM_PINS = 26)
(
	input wire REF_CLK,
	input wire ARST_N,
	input wire IN_SEL_WE,
	input wire [4:0] IN_SEL_IDX,
	input wire [4:0] IN_SEL_DATA,
	input wire OSC_LO_WE,
	input wire [7:0] OSC_LO_DATA,
	input wire SINGLE_SESSION_LOCK_CFG,
	input wire [19:0] PERIPH_OUT,
	input wire MAP_WRITE_LOCK,
	input wire MISMATCH_RST,
	input wire [25:0] PIN_OUT,
	input wire [25:0] PIN_PERIPH_OWN,
	input wire [124:0] IN_SEL_Q,
	input wire [129:0] OUT_SEL_Q
);
	wire [4:0] c = OUT_SEL_Q[4:0];
	wire lo = c > 5'h00 && c < 5'h11;
	wire own = lo || (c > 5'h11 && c < 5'h16);
	wire pv = own && (lo ? PERIPH_OUT[c - 5'h01] : PERIPH_OUT[c - 5'h02]);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!ARST_N);
	sequence s_key;
		OSC_LO_WE && OSC_LO_DATA == 8'h46 ##1
		OSC_LO_WE && OSC_LO_DATA == 8'h57 ##1 OSC_LO_WE;
	endsequence
	a_key_sets_lock: assert property (s_key |=> MAP_WRITE_LOCK ==
		($past(OSC_LO_DATA[6]) || SINGLE_SESSION_LOCK_CFG && $past(MAP_WRITE_LOCK)))
		else $error("lock wrong after key");
	a_lock_holds: assert property (!$past(OSC_LO_WE) |-> $stable(MAP_WRITE_LOCK))
		else $error("lock moved without write");
	a_one_way: assert property (SINGLE_SESSION_LOCK_CFG && MAP_WRITE_LOCK
		|=> MAP_WRITE_LOCK) else $error("one-way lock cleared");
	a_in_locked: assert property (MAP_WRITE_LOCK |=> $stable(IN_SEL_Q))
		else $error("input selector changed while locked");
	a_out_locked: assert property (MAP_WRITE_LOCK |=> $stable(OUT_SEL_Q))
		else $error("output selector changed while locked");
	a_in_write: assert property (IN_SEL_WE && !MAP_WRITE_LOCK &&
		IN_SEL_IDX == 5'h00 && IN_SEL_DATA < NUM_PINS
		|=> IN_SEL_Q[4:0] == $past(IN_SEL_DATA)) else $error("write lost");
	a_no_mismatch: assert property (!MISMATCH_RST)
		else $error("mismatch reset raised");
	a_pin_owner: assert property (PIN_PERIPH_OWN[0] == $past(own))
		else $error("pin owner wrong");
	a_pin_route: assert property (PIN_OUT[0] == $past(pv))
		else $error("pin output wrong");
endmodule // rpps_monitor
bind rpps_pin_select rpps_monitor #(.NUM_PINS(NUM_PINS)) rpps_monitor_i (.*);

// file: rpps_pin_select.v
// remappable peripheral pin select: selectors, lock, routing, shadow check
`timescale 1ns/1ns
`include "rpps_regs.vh"

module rpps_pin_select
#(
	parameter NUM_PINS = `RPPS_MAX_PINS
)
(
	input wire REF_CLK,
	input wire ARST_N,
	input wire IN_SEL_WE,
	input wire [4:0] IN_SEL_IDX,
	input wire [4:0] IN_SEL_DATA,
	input wire OUT_SEL_WE,
	input wire [4:0] OUT_SEL_IDX,
	input wire [4:0] OUT_SEL_DATA,
	input wire OSC_LO_WE,
	input wire [7:0] OSC_LO_DATA,
	input wire SINGLE_SESSION_LOCK_CFG,
	input wire [`RPPS_MAX_PINS-1:0] PIN_IN,
	input wire [`RPPS_NUM_OUT_FUNCS-1:0] PERIPH_OUT,
	output wire MAP_WRITE_LOCK,
	output wire MISMATCH_RST,
	output wire [`RPPS_NUM_IN_FUNCS-1:0] PERIPH_IN,
	output wire [`RPPS_MAX_PINS-1:0] PIN_OUT,
	output wire [`RPPS_MAX_PINS-1:0] PIN_PERIPH_OWN,
	output wire [`RPPS_NUM_IN_FUNCS*5-1:0] IN_SEL_Q,
	output wire [`RPPS_MAX_PINS*5-1:0] OUT_SEL_Q
);

////////////////////////////////////////////////////////////////////////////////
// peripheral input function indices

localparam in_fn_ext_irq_one = 5'h00;
localparam in_fn_ext_irq_two = 5'h01;
localparam in_fn_timer_two_ext_clock = 5'h02;
localparam in_fn_timer_three_ext_clock = 5'h03;
localparam in_fn_timer_four_ext_clock = 5'h04;
localparam in_fn_timer_five_ext_clock = 5'h05;
localparam in_fn_capture_one_in = 5'h06;
localparam in_fn_capture_two_in = 5'h07;
localparam in_fn_capture_seven_in = 5'h08;
localparam in_fn_capture_eight_in = 5'h09;
localparam in_fn_compare_fault_a = 5'h0a;
localparam in_fn_uart_one_receive = 5'h0b;
localparam in_fn_uart_one_clear_to_send = 5'h0c;
localparam in_fn_uart_two_receive = 5'h0d;
localparam in_fn_uart_two_clear_to_send = 5'h0e;
localparam in_fn_spi_one_data_in = 5'h0f;
localparam in_fn_spi_one_clock_in = 5'h10;
localparam in_fn_spi_one_select_in = 5'h11;
localparam in_fn_spi_two_data_in = 5'h12;
localparam in_fn_spi_two_clock_in = 5'h13;
localparam in_fn_spi_two_select_in = 5'h14;
localparam in_fn_audio_serial_data_in = 5'h15;
localparam in_fn_audio_serial_clock_in = 5'h16;
localparam in_fn_audio_frame_sync_in = 5'h17;
localparam in_fn_can_receive_in = 5'h18;

// peripheral output codes
localparam oc_comparator_one_out = 5'h01;
localparam oc_comparator_two_out = 5'h02;
localparam oc_uart_one_transmit = 5'h03;
localparam oc_uart_one_request_to_send = 5'h04;
localparam oc_uart_two_transmit = 5'h05;
localparam oc_uart_two_request_to_send = 5'h06;
localparam oc_spi_one_data_out = 5'h07;
localparam oc_spi_one_clock_out = 5'h08;
localparam oc_spi_one_select_out = 5'h09;
localparam oc_spi_two_data_out = 5'h0a;
localparam oc_spi_two_clock_out = 5'h0b;
localparam oc_spi_two_select_out = 5'h0c;
localparam oc_audio_serial_data_out = 5'h0d;
localparam oc_audio_serial_clock_out = 5'h0e;
localparam oc_audio_frame_sync_out = 5'h0f;
localparam oc_can_transmit_out = 5'h10;
localparam oc_compare_channel_one_out = 5'h12;
localparam oc_compare_channel_two_out = 5'h13;
localparam oc_compare_channel_three_out = 5'h14;
localparam oc_compare_channel_four_out = 5'h15;

////////////////////////////////////////////////////////////////////////////////
// lock and key sequence

reg map_write_lock_r;
reg [1:0] key_state_r;
reg one_way_latched_r;
reg [1:0] key_state_nxt;
reg map_write_lock_nxt;

always @*
begin
	key_state_nxt = key_state_r;
	map_write_lock_nxt = map_write_lock_r;
	if (OSC_LO_WE)
	begin
		case (key_state_r)
		`RPPS_KEY_IDLE:
		begin
			if (OSC_LO_DATA == `RPPS_KEY_FIRST)
				key_state_nxt = `RPPS_KEY_HALF;
		end
		`RPPS_KEY_HALF:
		begin
			if (OSC_LO_DATA == `RPPS_KEY_SECOND)
				key_state_nxt = `RPPS_KEY_ARMED;
			else if (OSC_LO_DATA == `RPPS_KEY_FIRST)
				key_state_nxt = `RPPS_KEY_HALF;
			else
				key_state_nxt = `RPPS_KEY_IDLE;
		end
		`RPPS_KEY_ARMED:
		begin
			key_state_nxt = `RPPS_KEY_IDLE;
			// one-way option refuses to clear a lock already set
			if (!(one_way_latched_r && SINGLE_SESSION_LOCK_CFG))
				map_write_lock_nxt = OSC_LO_DATA[`RPPS_LOCK_BIT];
		end
		default:
		begin
			key_state_nxt = `RPPS_KEY_IDLE;
		end
		endcase
	end
end

always @(posedge REF_CLK or negedge ARST_N)
begin
	if (!ARST_N)
	begin
		map_write_lock_r <= `RPPS_LOCK_RESET;
		key_state_r <= `RPPS_KEY_IDLE;
		one_way_latched_r <= 1'b0;
	end
	else
	begin
		map_write_lock_r <= map_write_lock_nxt;
		key_state_r <= key_state_nxt;
		if (map_write_lock_nxt)
			one_way_latched_r <= 1'b1;
	end
end

assign MAP_WRITE_LOCK = map_write_lock_r;

////////////////////////////////////////////////////////////////////////////////
// write acceptance

// value range follows the pin count of this variant
wire in_val_ok;
wire in_wr_ok;
wire out_wr_ok;

assign in_val_ok = (IN_SEL_DATA == `RPPS_IN_SEL_GROUND) ||
	({27'h0, IN_SEL_DATA} < NUM_PINS);
assign in_wr_ok = IN_SEL_WE && !map_write_lock_r && in_val_ok &&
	(IN_SEL_IDX <= in_fn_can_receive_in);
assign out_wr_ok = OUT_SEL_WE && !map_write_lock_r &&
	({27'h0, OUT_SEL_IDX} < NUM_PINS);

////////////////////////////////////////////////////////////////////////////////
// pin input synchronisers

reg [`RPPS_MAX_PINS-1:0] pin_s1_r;
reg [`RPPS_MAX_PINS-1:0] pin_s2_r;
reg [`RPPS_MAX_PINS-1:0] pin_s3_r;
reg [`RPPS_MAX_PINS-1:0] pin_stable_r;

always @(posedge REF_CLK or negedge ARST_N)
begin
	if (!ARST_N)
	begin
		pin_s1_r <= {`RPPS_MAX_PINS{1'b0}};
		pin_s2_r <= {`RPPS_MAX_PINS{1'b0}};
		pin_s3_r <= {`RPPS_MAX_PINS{1'b0}};
		pin_stable_r <= {`RPPS_MAX_PINS{1'b0}};
	end
	else
	begin
		pin_s1_r <= PIN_IN;
		pin_s2_r <= pin_s1_r;
		pin_s3_r <= pin_s2_r;
		pin_stable_r <= (pin_s2_r & pin_s3_r) |
			(pin_stable_r & (pin_s2_r ^ pin_s3_r));
	end
end

////////////////////////////////////////////////////////////////////////////////
// input selectors and input routing

reg [4:0] in_sel_r [0:`RPPS_NUM_IN_FUNCS-1];
reg [4:0] in_shadow_r [0:`RPPS_NUM_IN_FUNCS-1];
reg [`RPPS_NUM_IN_FUNCS-1:0] periph_in_r;
wire [`RPPS_NUM_IN_FUNCS-1:0] in_diff;

genvar gi;
generate
	for (gi = 0; gi < `RPPS_NUM_IN_FUNCS; gi = gi + 1)
	begin : g_in
		always @(posedge REF_CLK or negedge ARST_N)
		begin
			if (!ARST_N)
			begin
				in_sel_r[gi] <= `RPPS_IN_SEL_RESET;
				in_shadow_r[gi] <= `RPPS_IN_SEL_RESET;
				periph_in_r[gi] <= 1'b0;
			end
			else
			begin
				if (in_wr_ok && (IN_SEL_IDX == gi))
				begin
					in_sel_r[gi] <= IN_SEL_DATA;
					in_shadow_r[gi] <= IN_SEL_DATA;
				end
				if (in_sel_r[gi] == `RPPS_IN_SEL_GROUND)
					periph_in_r[gi] <= 1'b0;
				else if ({27'h0, in_sel_r[gi]} < NUM_PINS)
					periph_in_r[gi] <= pin_stable_r[in_sel_r[gi]];
				else
					periph_in_r[gi] <= 1'b0;
			end
		end
		assign in_diff[gi] = (in_sel_r[gi] != in_shadow_r[gi]);
		assign IN_SEL_Q[gi*5 +: 5] = in_sel_r[gi];
	end
endgenerate

assign PERIPH_IN = periph_in_r;

////////////////////////////////////////////////////////////////////////////////
// output selectors and output routing, independent of the input side

reg [4:0] out_sel_r [0:`RPPS_MAX_PINS-1];
reg [4:0] out_shadow_r [0:`RPPS_MAX_PINS-1];
reg [`RPPS_MAX_PINS-1:0] pin_out_r;
reg [`RPPS_MAX_PINS-1:0] pin_own_r;
wire [`RPPS_MAX_PINS-1:0] out_diff;

genvar go;
generate
	for (go = 0; go < `RPPS_MAX_PINS; go = go + 1)
	begin : g_out
		wire [4:0] code;
		reg route_hit;
		reg [4:0] route_idx;
		assign code = out_sel_r[go];
		// code to peripheral output index; unused codes stay with the port
		always @*
		begin
			route_hit = 1'b1;
			route_idx = 5'h00;
			case (code)
			oc_comparator_one_out: route_idx = 5'h00;
			oc_comparator_two_out: route_idx = 5'h01;
			oc_uart_one_transmit: route_idx = 5'h02;
			oc_uart_one_request_to_send: route_idx = 5'h03;
			oc_uart_two_transmit: route_idx = 5'h04;
			oc_uart_two_request_to_send: route_idx = 5'h05;
			oc_spi_one_data_out: route_idx = 5'h06;
			oc_spi_one_clock_out: route_idx = 5'h07;
			oc_spi_one_select_out: route_idx = 5'h08;
			oc_spi_two_data_out: route_idx = 5'h09;
			oc_spi_two_clock_out: route_idx = 5'h0a;
			oc_spi_two_select_out: route_idx = 5'h0b;
			oc_audio_serial_data_out: route_idx = 5'h0c;
			oc_audio_serial_clock_out: route_idx = 5'h0d;
			oc_audio_frame_sync_out: route_idx = 5'h0e;
			oc_can_transmit_out: route_idx = 5'h0f;
			oc_compare_channel_one_out: route_idx = 5'h10;
			oc_compare_channel_two_out: route_idx = 5'h11;
			oc_compare_channel_three_out: route_idx = 5'h12;
			oc_compare_channel_four_out: route_idx = 5'h13;
			default: route_hit = 1'b0;
			endcase
		end
		always @(posedge REF_CLK or negedge ARST_N)
		begin
			if (!ARST_N)
			begin
				out_sel_r[go] <= `RPPS_OUT_SEL_RESET;
				out_shadow_r[go] <= `RPPS_OUT_SEL_RESET;
				pin_out_r[go] <= 1'b0;
				pin_own_r[go] <= 1'b0;
			end
			else
			begin
				if (out_wr_ok && (OUT_SEL_IDX == go))
				begin
					out_sel_r[go] <= OUT_SEL_DATA;
					out_shadow_r[go] <= OUT_SEL_DATA;
				end
				if (go >= NUM_PINS)
				begin
					pin_out_r[go] <= 1'b0;
					pin_own_r[go] <= 1'b0;
				end
				else if (route_hit)
				begin
					pin_out_r[go] <= PERIPH_OUT[route_idx];
					pin_own_r[go] <= 1'b1;
				end
				else
				begin
					pin_out_r[go] <= 1'b0;
					pin_own_r[go] <= 1'b0;
				end
			end
		end
		assign out_diff[go] = (out_sel_r[go] != out_shadow_r[go]);
		assign OUT_SEL_Q[go*5 +: 5] = out_sel_r[go];
	end
endgenerate

assign PIN_OUT = pin_out_r;
assign PIN_PERIPH_OWN = pin_own_r;

////////////////////////////////////////////////////////////////////////////////
// continuous state monitoring

reg mismatch_r;

always @(posedge REF_CLK or negedge ARST_N)
begin
	if (!ARST_N)
		mismatch_r <= 1'b0;
	else
		mismatch_r <= (|in_diff) | (|out_diff);
end

assign MISMATCH_RST = mismatch_r;

endmodule // rpps_pin_select

// file: rpps_pin_select_test.sv
// self-checking bench for the pin select block
`timescale 1ns/1ns
module rpps_pin_select_test;
	reg clk = 1'b0, rst_n = 1'b0, iwe = 1'b0, owe = 1'b0, kwe = 1'b0;
	reg cfg = 1'b0, el = 1'b0;
	reg [4:0] ix = 5'h00, id = 5'h00, ox = 5'h00, od = 5'h00, g;
	reg [7:0] kd = 8'h00;
	reg [19:0] ps = 20'h00000;
	reg [25:0] ls = 26'h0000000;
	wire [19:0] po;
	wire [25:0] pn, pq, on;
	wire [24:0] pi;
	wire [124:0] iq;
	wire [129:0] oq;
	wire lk, mm;
	reg [31:0] r = 32'h99edc489;
	reg [4:0] isel [0:24];
	reg [4:0] osel [0:25];
	reg [12:0] q [$];
	reg [12:0] n;
	integer miscompares = 0, total_checks = 0, i, k;
	always #10 clk = ~clk;
	rpps_pin_select #(.NUM_PINS(26)) rpps_pin_select_i (.REF_CLK(clk),
		.ARST_N(rst_n), .IN_SEL_WE(iwe), .IN_SEL_IDX(ix), .IN_SEL_DATA(id),
		.OUT_SEL_WE(owe), .OUT_SEL_IDX(ox), .OUT_SEL_DATA(od),
		.OSC_LO_WE(kwe), .OSC_LO_DATA(kd), .SINGLE_SESSION_LOCK_CFG(cfg),
		.PIN_IN(pn), .PERIPH_OUT(po), .MAP_WRITE_LOCK(lk), .MISMATCH_RST(mm),
		.PERIPH_IN(pi), .PIN_OUT(pq), .PIN_PERIPH_OWN(on), .IN_SEL_Q(iq),
		.OUT_SEL_Q(oq));
	rpps_far_model rpps_far_model_i (.clk(clk), .per_set(ps), .pin_set(ls),
		.periph_out(po), .pin_in(pn));
	////////////////////////////////////////
	function [31:0] nx(input [31:0] s);
		nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task ex(input [2:0] t, input [4:0] x, input [4:0] v);
		q.push_back({t, x, v});
	endtask
	task wr(input o, input [4:0] x, input [4:0] v);
	begin
		@(posedge clk);
		iwe <= !o;
		owe <= o;
		ix <= x;
		ox <= x;
		id <= v;
		od <= v;
		@(posedge clk);
		iwe <= 1'b0;
		owe <= 1'b0;
		if (!el && o)
			osel[x] = v;
		if (!el && !o && (v < 5'h1a || v == 5'h1f))
			isel[x] = v;
		ex({2'b00, o}, x, o ? osel[x] : isel[x]);
	end
	endtask
	task osw(input [7:0] d);
	begin
		@(posedge clk);
		kwe <= 1'b1;
		kd <= d;
		@(posedge clk);
		kwe <= 1'b0;
	end
	endtask
	task key(input [7:0] b);
	begin
		@(posedge clk);
		kwe <= 1'b1;
		kd <= 8'h46;
		@(posedge clk);
		kd <= 8'h57;
		osw(b);
		el = b[6] | (cfg & el);
		ex(3'd2, 5'h00, {4'h0, el});
	end
	endtask
	task rs(input c);
	begin
		@(posedge clk);
		rst_n <= 1'b0;
		cfg <= c;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		el = 1'b0;
		for (i = 0; i < 26; i = i + 1)
		begin
			osel[i] = 5'h00;
			ex(3'd1, 5'(i), 5'h00);
			if (i < 25)
				isel[i] = 5'h1f;
			if (i < 25)
				ex(3'd0, 5'(i), 5'h1f);
		end
		ex(3'd2, 5'h00, 5'h00);
	end
	endtask
	task rt;
		integer j, c;
	begin
		r = nx(r);
		ps <= r[19:0];
		r = nx(r);
		ls <= r[25:0];
		repeat (8) @(posedge clk);
		ex(3'd6, 5'h00, 5'h00);
		for (j = 0; j < 26; j = j + 1)
		begin
			c = osel[j];
			ex(3'd5, 5'(j), (c > 0 && c < 17) || (c > 17 && c < 22));
			ex(3'd4, 5'(j), (c > 0 && c < 17) ? ps[c - 1] :
				(c > 17 && c < 22) ? ps[c - 2] : 1'b0);
			if (j < 25)
				ex(3'd3, 5'(j), isel[j] == 5'h1f ? 1'b0 : ls[isel[j]]);
		end
	end
	endtask
	task test_done;
	begin
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	end
	endtask
	////////////////////////////////////////
	always @(negedge clk)
		while (q.size() > 0)
		begin
			n = q.pop_front();
			case (n[12:10])
				3'd0: g = iq[n[9:5] * 5 +: 5];
				3'd1: g = oq[n[9:5] * 5 +: 5];
				3'd2: g = {4'h0, lk};
				3'd3: g = {4'h0, pi[n[9:5]]};
				3'd4: g = {4'h0, pq[n[9:5]]};
				3'd6: g = {4'h0, mm};
				default: g = {4'h0, on[n[9:5]]};
			endcase
			total_checks = total_checks + 1;
			if (g !== n[4:0])
			begin
				miscompares = miscompares + 1;
				$display("BAD %0t got %h exp %h", $time, g, n[4:0]);
			end
		end
	initial
	begin
		repeat (30000) @(posedge clk);
		miscompares = miscompares + 1;
		test_done;
	end
	initial
	begin
		rs(1'b0);
		for (k = 0; k < 2; k = k + 1)
		begin
			for (i = 0; i < 26; i = i + 1)
				wr(1'b1, 5'(i), 5'(i + k * 6));
			for (i = 0; i < 25; i = i + 1)
			begin
				r = nx(r);
				wr(1'b0, 5'(i), i == 24 ? 5'h1f : 5'(r % 26));
			end
			rt;
		end
		wr(1'b0, 5'h01, 5'h1a);
		key(8'h40);
		wr(1'b0, 5'h00, 5'h03);
		wr(1'b1, 5'h02, 5'h07);
		osw(8'h46);
		osw(8'h00);
		osw(8'h57);
		osw(8'h00);
		ex(3'd2, 5'h00, 5'h01);
		key(8'h00);
		wr(1'b0, 5'h00, 5'h05);
		wr(1'b1, 5'h00, 5'h11);
		rs(1'b1);
		key(8'h40);
		key(8'h00);
		wr(1'b1, 5'h00, 5'h03);
		rs(1'b1);
		repeat (2) @(posedge clk);
		test_done;
	end
endmodule // rpps_pin_select_test

// file: rpps_regs.vh
// constants for the remappable peripheral pin select block
`ifndef RPPS_REGS_VH
`define RPPS_REGS_VH
`define RPPS_SEL_W 5
`define RPPS_MAX_PINS 26
`define RPPS_NUM_IN_FUNCS 25
`define RPPS_NUM_OUT_FUNCS 20
`define RPPS_NUM_IN_REGS 16
`define RPPS_NUM_OUT_REGS 13
`define RPPS_IN_SEL_RESET 5'h1f
`define RPPS_IN_SEL_GROUND 5'h1f
`define RPPS_OUT_SEL_RESET 5'h00
`define RPPS_OUT_NULL 5'h00
`define RPPS_OUT_LAST_LOW 5'h10
`define RPPS_OUT_FIRST_HIGH 5'h12
`define RPPS_OUT_LAST_HIGH 5'h15
`define RPPS_OUT_LOW_BASE 5'h01
`define RPPS_OUT_HIGH_BASE 5'h02
`define RPPS_KEY_FIRST 8'h46
`define RPPS_KEY_SECOND 8'h57
`define RPPS_LOCK_BIT 6
`define RPPS_LOCK_RESET 1'b0
`define RPPS_KEY_IDLE 2'h0
`define RPPS_KEY_HALF 2'h1
`define RPPS_KEY_ARMED 2'h2
`endif
